/* core/light_sensor_regs.svh */
/*
  Register constants for the light sensor register block: command codes,
  field positions and reset values.
  Assumes it is included by its bare name and holds definitions only.
*/
`ifndef LIGHT_SENSOR_REGS_SVH
`define LIGHT_SENSOR_REGS_SVH

`define CMD_UPPER_BOUND   8'h01
`define CMD_LOWER_BOUND   8'h02
`define CMD_POWER_SAVE    8'h03
`define CMD_LIGHT_RESULT  8'h04
`define CMD_WHITE_RESULT  8'h05

`define PSM_SEL_HI        2
`define PSM_SEL_LO        1
`define PSM_ON_BIT        0

`define RST_BOUND         16'h0000
`define RST_POWER_SAVE    3'h0
`define RST_RESULT        16'h0000
`define RST_DEV_ADDR      7'h10

`define BYTE_BITS         4'h8

`endif

/* core/light_sensor_pkg.sv */
/*
  Types for the light sensor register block: serial state machine and the
  packed state of the top module.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package light_sensor_pkg;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_CMD,
    ST_CMD_ACK,
    ST_WR_DATA,
    ST_WR_ACK,
    ST_RD_DATA,
    ST_RD_ACK
  } serial_state_t;

  typedef struct packed {
    logic          scl_s1;
    logic          scl_s2;
    logic          scl_d;
    logic          sda_s1;
    logic          sda_s2;
    logic          sda_d;
    serial_state_t st;
    logic [3:0]    cnt;
    logic [7:0]    shift;
    logic [7:0]    tx;
    logic [7:0]    cmd;
    logic          rw;
    logic          byte_hi;
    logic          nack;
    logic          drive;
    logic [7:0]    low_hold;
    logic [15:0]   rd_word;
    logic [15:0]   upper;
    logic [15:0]   lower;
    logic [2:0]    power_saving_control;
    logic [15:0]   light;
    logic [15:0]   white;
    logic          below;
    logic          above;
  } sensor_state_t;

endpackage

/* core/light_sensor_threshold_result_regs.sv */
/*
  Two-wire serial register slave of an ambient light sensor: threshold
  window bounds, power saving control and the two result words.
  Assumes serial clock and data arrive asynchronously and are oversampled by
  clk (100 MHz); measurements and control levels come from logic on clk.
*/
`timescale 1ns/1ps
`include "light_sensor_regs.svh"

// Contract
// - Upper window bound written at code 01h
// - Upper bound: high byte 15:8, low 7:0
// - Lower window bound written at code 02h
// - Lower bound: high byte 15:8, low 7:0
// - Code 03h bits 2:1 pick mode
// - Code 03h bit 0 enables power saving
// - Light result read at code 04h
// - Light result: high byte 15:8, low 7:0
// - White result read at code 05h
// - White result: high byte 15:8, low 7:0
// - Window compare only while interrupt enabled
// - Below lower bound sets low flag
// - Above upper bound sets high flag
// - Shutdown holds results; wake-up refreshes them
module light_sensor_threshold_result_regs
  import light_sensor_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `RST_DEV_ADDR
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Serial pins, open drain data
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n,
  // Measurement side
  input  wire logic [15:0] meas_light,
  input  wire logic [15:0] meas_white,
  input  wire logic        meas_valid,
  input  wire logic        shutdown,
  input  wire logic        light_irq_on,
  input  wire logic        flag_clear,
  // Register contents
  output logic [15:0]      window_upper_bound,
  output logic [15:0]      window_lower_bound,
  output logic [1:0]       power_save_select,
  output logic             power_save_on,
  output logic [15:0]      light_channel,
  output logic [15:0]      white_channel,
  output logic             below_window_flag,
  output logic             above_window_flag
);

  sensor_state_t r;
  sensor_state_t nxt;

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic wr_commit;

  // Edges are found on the second sync stage only
  assign scl_rise  = r.scl_s2 & ~r.scl_d;
  assign scl_fall  = ~r.scl_s2 & r.scl_d;
  assign bus_start = r.scl_s2 & r.scl_d & r.sda_d & ~r.sda_s2;
  assign bus_stop  = r.scl_s2 & r.scl_d & ~r.sda_d & r.sda_s2;
  assign wr_commit = scl_fall & (r.st == ST_WR_DATA) & (r.cnt == `BYTE_BITS) & r.byte_hi;

  always_comb begin
    nxt = r;
    nxt.scl_s1 = scl_i;
    nxt.scl_s2 = r.scl_s1;
    nxt.scl_d  = r.scl_s2;
    nxt.sda_s1 = sda_i;
    nxt.sda_s2 = r.sda_s1;
    nxt.sda_d  = r.sda_s2;

    if (bus_start) begin
      nxt.st    = ST_ADDR;
      nxt.cnt   = 4'h0;
      nxt.drive = 1'b0;
    end else if (bus_stop) begin
      nxt.st    = ST_IDLE;
      nxt.drive = 1'b0;
    end else if (scl_rise) begin
      case (r.st)
        ST_ADDR, ST_CMD, ST_WR_DATA: begin
          nxt.shift = {r.shift[6:0], r.sda_s2};
          nxt.cnt   = r.cnt + 4'h1;
        end
        ST_RD_ACK: nxt.nack = r.sda_s2;
        default: ;
      endcase
    end else if (scl_fall) begin
      case (r.st)
        ST_ADDR: begin
          if (r.cnt == `BYTE_BITS) begin
            if (r.shift[7:1] == DEV_ADDR) begin
              nxt.st      = ST_ADDR_ACK;
              nxt.drive   = 1'b1;
              nxt.rw      = r.shift[0];
              nxt.byte_hi = 1'b0;
              // Snapshot so both bytes of one read belong to the same word
              case (r.cmd)
                `CMD_LIGHT_RESULT: nxt.rd_word = r.light;
                `CMD_WHITE_RESULT: nxt.rd_word = r.white;
                default:           nxt.rd_word = 16'h0000;
              endcase
            end else begin
              nxt.st = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          nxt.cnt = 4'h0;
          if (r.rw) begin
            nxt.st    = ST_RD_DATA;
            nxt.tx    = r.rd_word[7:0];
            nxt.drive = ~r.rd_word[7];
          end else begin
            nxt.st    = ST_CMD;
            nxt.drive = 1'b0;
          end
        end
        ST_CMD: begin
          if (r.cnt == `BYTE_BITS) begin
            nxt.cmd     = r.shift;
            nxt.st      = ST_CMD_ACK;
            nxt.drive   = 1'b1;
            nxt.byte_hi = 1'b0;
          end
        end
        ST_CMD_ACK, ST_WR_ACK: begin
          nxt.st    = ST_WR_DATA;
          nxt.cnt   = 4'h0;
          nxt.drive = 1'b0;
        end
        ST_WR_DATA: begin
          if (r.cnt == `BYTE_BITS) begin
            nxt.st      = ST_WR_ACK;
            nxt.drive   = 1'b1;
            nxt.byte_hi = ~r.byte_hi;
            if (!r.byte_hi) begin
              nxt.low_hold = r.shift;
            end else begin
              // Whole word lands at once, so logic never sees a half-written bound
              case (r.cmd)
                `CMD_UPPER_BOUND: nxt.upper = {r.shift, r.low_hold};
                `CMD_LOWER_BOUND: nxt.lower = {r.shift, r.low_hold};
                `CMD_POWER_SAVE:  nxt.power_saving_control   = r.low_hold[`PSM_SEL_HI:`PSM_ON_BIT];
                default: ;
              endcase
            end
          end
        end
        ST_RD_DATA: begin
          nxt.cnt = r.cnt + 4'h1;
          if (r.cnt == 4'h7) begin
            nxt.st    = ST_RD_ACK;
            nxt.drive = 1'b0;
          end else begin
            nxt.tx    = {r.tx[6:0], 1'b0};
            nxt.drive = ~r.tx[6];
          end
        end
        ST_RD_ACK: begin
          nxt.cnt = 4'h0;
          if (r.nack) begin
            nxt.st    = ST_IDLE;
            nxt.drive = 1'b0;
          end else begin
            nxt.st      = ST_RD_DATA;
            nxt.byte_hi = ~r.byte_hi;
            nxt.tx      = r.byte_hi ? r.rd_word[7:0] : r.rd_word[15:8];
            nxt.drive   = r.byte_hi ? ~r.rd_word[7] : ~r.rd_word[15];
          end
        end
        default: nxt.st = ST_IDLE;
      endcase
    end

    // Results freeze in shutdown and refresh after wake-up
    if (meas_valid && !shutdown) begin
      nxt.light = meas_light;
      nxt.white = meas_white;
    end

    // Clear first, so a crossing in the clear cycle still sets the flag
    if (flag_clear) begin
      nxt.below = 1'b0;
      nxt.above = 1'b0;
    end
    if (meas_valid && light_irq_on) begin
      if (meas_light < r.lower) nxt.below = 1'b1;
      if (meas_light > r.upper) nxt.above = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r         <= '0;
      r.scl_s1  <= 1'b1;
      r.scl_s2  <= 1'b1;
      r.scl_d   <= 1'b1;
      r.sda_s1  <= 1'b1;
      r.sda_s2  <= 1'b1;
      r.sda_d   <= 1'b1;
      r.st      <= ST_IDLE;
      r.upper   <= `RST_BOUND;
      r.lower   <= `RST_BOUND;
      r.power_saving_control     <= `RST_POWER_SAVE;
      r.light   <= `RST_RESULT;
      r.white   <= `RST_RESULT;
    end else begin
      r <= nxt;
    end
  end

  assign sda_o              = 1'b0;
  assign sda_oe_n           = ~r.drive;
  assign window_upper_bound = r.upper;
  assign window_lower_bound = r.lower;
  assign power_save_select  = r.power_saving_control[`PSM_SEL_HI:`PSM_SEL_LO];
  assign power_save_on      = r.power_saving_control[`PSM_ON_BIT];
  assign light_channel      = r.light;
  assign white_channel      = r.white;
  assign below_window_flag  = r.below;
  assign above_window_flag  = r.above;

  a_upper_commit: assert property (@(posedge clk) disable iff (!nrst)
    wr_commit && r.cmd == `CMD_UPPER_BOUND |=>
      window_upper_bound == {$past(r.shift), $past(r.low_hold)})
    else $error("Upper bound not taken from the two data bytes");

  a_lower_commit: assert property (@(posedge clk) disable iff (!nrst)
    wr_commit && r.cmd == `CMD_LOWER_BOUND |=>
      window_lower_bound[15:8] == $past(r.shift) && window_lower_bound[7:0] == $past(r.low_hold))
    else $error("Lower bound bytes misplaced");

  a_power_fields: assert property (@(posedge clk) disable iff (!nrst)
    wr_commit && r.cmd == `CMD_POWER_SAVE |=>
      power_save_select == $past(r.low_hold[2:1]) && power_save_on == $past(r.low_hold[0]))
    else $error("Power save fields not taken from bits 2:0");

  a_bound_stable: assert property (@(posedge clk) disable iff (!nrst)
    !wr_commit |=> $stable(window_upper_bound) && $stable(window_lower_bound) && $stable(power_save_on))
    else $error("Register changed without a write");

  a_first_low: assert property (@(posedge clk) disable iff (!nrst)
    r.st == ST_ADDR_ACK && r.rw && scl_fall |=> r.drive == ~r.rd_word[7] && r.tx == r.rd_word[7:0])
    else $error("Read did not start with the low byte");

  a_result_hold: assert property (@(posedge clk) disable iff (!nrst)
    shutdown |=> $stable(light_channel) && $stable(white_channel))
    else $error("Result changed during shutdown");

  a_result_update: assert property (@(posedge clk) disable iff (!nrst)
    meas_valid && !shutdown |=> light_channel == $past(meas_light) && white_channel == $past(meas_white))
    else $error("Result not refreshed by new measurement");

  a_below_set: assert property (@(posedge clk) disable iff (!nrst)
    meas_valid && light_irq_on && meas_light < window_lower_bound |=> below_window_flag)
    else $error("Low flag not set below the window");

  a_above_set: assert property (@(posedge clk) disable iff (!nrst)
    meas_valid && light_irq_on && meas_light > window_upper_bound |=> above_window_flag)
    else $error("High flag not set above the window");

  a_irq_gate: assert property (@(posedge clk) disable iff (!nrst)
    !light_irq_on && !below_window_flag && !above_window_flag |=> !below_window_flag && !above_window_flag)
    else $error("Flag set while interrupt disabled");

endmodule // light_sensor_threshold_result_regs

/* tb/i2c_host_model.sv */
/*
  Two-wire host model: drives the serial clock and its side of the
  open-drain data line. Assumes a pull-up on data.
*/
`timescale 1ns/1ps
module i2c_host_model #(
  parameter logic [6:0] ADR = 7'h10
) (
  // Device enable on data, low pulls low
  input  wire logic sda_dev_oe_n,
  // Bus lines
  output logic      scl,
  output logic      sda
);
  logic rel;
  // Wired AND with pull-up; released line reads high
  assign sda = rel & sda_dev_oe_n;
  initial begin
    scl = 1'b1;
    rel = 1'b1;
  end
  // Clock stands high between frames; 160 ns per bit
  task automatic bit_io(input logic b, output logic s);
    rel = b;
    #40 scl = 1'b1;
    #80 s = sda;
    scl = 1'b0;
    #40;
  endtask
  task automatic start_c(input logic again);
    rel = 1'b1;
    if (again) #40 scl = 1'b1;
    #80 rel = 1'b0;
    #80 scl = 1'b0;
    #40;
  endtask
  task automatic stop_c();
    rel = 1'b0;
    #40 scl = 1'b1;
    #80 rel = 1'b1;
    #80;
  endtask
  task automatic byte_io(input logic [7:0] tx, input logic ai, output logic [7:0] rx,
                         output logic ao);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ai, ao);
  endtask
  task automatic write_word(input logic [6:0] a, input logic [7:0] cmd,
                            input logic [15:0] w, output logic nk);
    logic [7:0] d;
    logic [3:0] k;
    start_c(1'b0);
    byte_io({a, 1'b0}, 1'b1, d, k[0]);
    byte_io(cmd, 1'b1, d, k[1]);
    byte_io(w[7:0], 1'b1, d, k[2]);
    byte_io(w[15:8], 1'b1, d, k[3]);
    stop_c();
    nk = |k;
  endtask
  task automatic read_word(input logic [7:0] cmd, output logic [15:0] w);
    logic a;
    start_c(1'b0);
    byte_io({ADR, 1'b0}, 1'b1, w[7:0], a);
    byte_io(cmd, 1'b1, w[7:0], a);
    start_c(1'b1);
    byte_io({ADR, 1'b1}, 1'b1, w[7:0], a);
    byte_io(8'hFF, 1'b0, w[7:0], a);
    byte_io(8'hFF, 1'b1, w[15:8], a);
    stop_c();
  endtask
endmodule // i2c_host_model

/* tb/testbench.sv */
/*
  Self-checking bench: register writes and reads over the host model,
  measurements, window flags and shutdown hold.
  Assumes the package, design and host model are compiled first.
*/
`timescale 1ns/1ps
module testbench
  import light_sensor_pkg::*;
;
  localparam logic [6:0] ADR = 7'h10;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        scl;
  logic        sda;
  logic        sda_o;
  logic        sda_oe_n;
  logic [15:0] ml = 16'h0000;
  logic [15:0] mw = 16'h0000;
  logic        mv = 1'b0;
  logic        shutdown = 1'b0;
  logic        irq_on = 1'b0;
  logic        fclr = 1'b0;
  logic [15:0] upper, lower, light, white, rd;
  logic [1:0]  psel;
  logic        pon, below, above, nk;
  int          mismatches = 0;
  int          samples_checked = 0;
  always #5 clk = ~clk;
  light_sensor_threshold_result_regs #(.DEV_ADDR(ADR)) light_sensor_threshold_result_regs_i (
    .clk(clk), .nrst(nrst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .meas_light(ml), .meas_white(mw), .meas_valid(mv), .shutdown(shutdown),
    .light_irq_on(irq_on), .flag_clear(fclr), .window_upper_bound(upper),
    .window_lower_bound(lower), .power_save_select(psel), .power_save_on(pon),
    .light_channel(light), .white_channel(white), .below_window_flag(below),
    .above_window_flag(above));
  i2c_host_model #(.ADR(ADR)) i2c_host_model_i (
    .sda_dev_oe_n(sda_oe_n), .scl(scl), .sda(sda));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask
  task automatic measure(input logic [15:0] l, input logic [15:0] w);
    @(posedge clk) #1;
    ml = l;
    mw = w;
    mv = 1'b1;
    @(posedge clk) #1;
    mv = 1'b0;
  endtask
  task automatic t_bounds();
    i2c_host_model_i.write_word(ADR, 8'h01, 16'hABCD, nk);
    chk("ack", 16'h0000, {15'h0000, nk});
    chk("upper", 16'hABCD, upper);
    i2c_host_model_i.write_word(ADR, 8'h02, 16'h1234, nk);
    chk("lower ack", 16'h0000, {15'h0000, nk});
    chk("lower", 16'h1234, lower);
    i2c_host_model_i.write_word(7'h48, 8'h01, 16'h5555, nk);
    chk("foreign", 16'h0001, {15'h0000, nk});
    chk("upper kept", 16'hABCD, upper);
    i2c_host_model_i.read_word(8'h01, rd);
    chk("wo read", 16'h0000, rd);
  endtask
  task automatic t_psm();
    for (int m = 0; m < 8; m++) begin
      i2c_host_model_i.write_word(ADR, 8'h03, {13'h0000, 3'(m)}, nk);
      chk("select", 16'(m >> 1), {14'h0000, psel});
      chk("enable", 16'(m & 1), {15'h0000, pon});
    end
  endtask
  task automatic t_results();
    measure(16'h5A3C, 16'hC3A5);
    chk("light", 16'h5A3C, light);
    chk("white", 16'hC3A5, white);
    i2c_host_model_i.read_word(8'h04, rd);
    chk("light rd", 16'h5A3C, rd);
    i2c_host_model_i.read_word(8'h05, rd);
    chk("white rd", 16'hC3A5, rd);
    i2c_host_model_i.read_word(8'h06, rd);
    chk("unmapped", 16'h0000, rd);
  endtask
  task automatic t_flags();
    measure(16'h0001, 16'h0000);
    chk("gated", 16'h0000, {14'h0000, below, above});
    irq_on = 1'b1;
    measure(16'h1234, 16'h0000);
    chk("at lower", 16'h0000, {14'h0000, below, above});
    measure(16'hABCD, 16'h0000);
    chk("at upper", 16'h0000, {14'h0000, below, above});
    measure(16'h1233, 16'h0000);
    chk("below", 16'h0002, {14'h0000, below, above});
    fclr = 1'b1;
    @(posedge clk) #1;
    fclr = 1'b0;
    measure(16'hABCE, 16'h0001);
    chk("above", 16'h0001, {14'h0000, below, above});
    // Clear held across a crossing: the new set must survive the clear
    fclr = 1'b1;
    measure(16'h0001, 16'h0002);
    fclr = 1'b0;
    chk("set wins", 16'h0002, {14'h0000, below, above});
  endtask
  task automatic t_shutdown();
    shutdown = 1'b1;
    measure(16'h0F0F, 16'hF0F0);
    i2c_host_model_i.read_word(8'h04, rd);
    chk("held", 16'h0001, rd);
    chk("held w", 16'h0002, white);
    @(posedge clk) #1;
    shutdown = 1'b0;
    measure(16'h0F0F, 16'hF0F0);
    chk("woken", 16'h0F0F, light);
    chk("woken w", 16'hF0F0, white);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("reset", 16'h0000, upper | lower | light | white);
    chk("reset pins", 16'h0040, {9'h000, sda_oe_n, sda_o, below, above, psel, pon});
    t_bounds();
    t_psm();
    t_results();
    t_flags();
    t_shutdown();
    final_report();
  end
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    final_report();
  end
endmodule // testbench
